// File: shared/nco_pkg.sv
// How it works
// RQ1 - accumulator is 20 bits over low, high and upper bytes; 24-bit space
// RQ2 - accumulator bytes change live on the input clock; multi-byte reads not atomic
// RQ3 - software must not write accumulator bytes while running; result undefined
// RQ4 - step value is upper nibble, high byte, low byte, msb to lsb
// RQ5 - shadow step reloads on first input clock fall after low step write
// RQ6 - software writes upper and high step bytes before the low byte
// RQ7 - bits 7 to 4 of both upper bytes are unimplemented, read zero
// RQ8 - overflow sets a sticky flag that software clears
// RQ9 - mode bit: one gives pulse per overflow, zero toggles per overflow
// RQ10 - pulse width is 2 to the field value input clock periods
// RQ11 - polarity bit one inverts the final output
// RQ12 - enabled input clock rise adds shadow step modulo 2^20; carry is overflow
`default_nettype none
package nco_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int ACC_W  = 20;
  localparam int UPR_W  = 4;
  localparam int NSRC   = 11;
  localparam int CKS_W  = 4;
  localparam int PWS_W  = 3;
  localparam int PCNT_W = 8;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADR_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_CLK   = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_ACCL  = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_ACCH  = 4'h3;
  localparam logic [ADDR_W-1:0] ADR_ACCU  = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_INCL  = 4'h5;
  localparam logic [ADDR_W-1:0] ADR_INCH  = 4'h6;
  localparam logic [ADDR_W-1:0] ADR_INCU  = 4'h7;
  localparam logic [ADDR_W-1:0] ADR_ISTAT = 4'h8;
  localparam logic [ADDR_W-1:0] ADR_ICLR  = 4'h9;
  localparam logic [ADDR_W-1:0] ADR_IEN   = 4'hA;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_EN  = 7;
  localparam int CTRL_OUT = 5;
  localparam int CTRL_POL = 4;
  localparam int CTRL_PFM = 0;
  localparam int CLK_PWS  = 5;
  localparam int IRQ_OVF  = 0;
  localparam int BYTE_L   = 0;
  localparam int BYTE_H   = 1;
  localparam int BYTE_U   = 2;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] RST_INCL = 8'h01;
  localparam logic [ACC_W-1:0]  RST_STEP = 20'h00001;
  localparam logic [ACC_W-1:0]  RST_ACC  = 20'h00000;
  localparam logic [UPR_W-1:0]  UPR_PAD  = 4'h0;
  localparam logic [PCNT_W-1:0] PCNT_ONE = 8'h01;
endpackage
`default_nettype wire

// File: shared/nco_acc_if.sv
`timescale 1ns/1ps
`default_nettype none
// accumulator hand-off between register side and adder
interface nco_acc_if;
  import nco_pkg::*;
  logic              tick;     // enabled input clock rise
  logic [ACC_W-1:0]  step;     // shadow step value
  logic [2:0]        wr_byte;  // accumulator byte write strobes
  logic [DATA_W-1:0] wr_data;  // byte write data
  logic [ACC_W-1:0]  acc;      // live accumulator
  logic              ovf;      // carry out pulse
  modport core  (output tick, step, wr_byte, wr_data, input acc, ovf);
  modport accum (input tick, step, wr_byte, wr_data, output acc, ovf);
endinterface
`default_nettype wire

// File: logic/nco_sync.sv
`timescale 1ns/1ps
`default_nettype none
module nco_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // system clock
  input  wire logic         rstn,  // async reset, low
  input  wire logic         ce,    // clock enable
  input  wire logic [W-1:0] d,     // asynchronous inputs
  output var  logic [W-1:0] q      // synchronised outputs
);
  logic [W-1:0] s1;
  // two flops per source; s1 feeds only q
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        s1[i] <= 1'b0;
        q[i]  <= 1'b0;
      end else if (ce) begin
        s1[i] <= d[i];
        q[i]  <= s1[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/nco_accum.sv
`timescale 1ns/1ps
`default_nettype none
module nco_accum (
  input  wire logic clk,   // system clock
  input  wire logic rstn,  // async reset, low
  input  wire logic ce,    // clock enable
  nco_acc_if.accum  aif    // accumulator link
);
  import nco_pkg::*;
  logic [ACC_W:0] sum;
  assign sum = {1'b0, aif.acc} + {1'b0, aif.step};
  // byte writes beat the adder; running writes are undefined anyway
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aif.acc <= RST_ACC;
      aif.ovf <= 1'b0;
    end else if (ce) begin
      aif.ovf <= 1'b0;
      if (aif.wr_byte[BYTE_L]) begin
        aif.acc[7:0] <= aif.wr_data;
      end else if (aif.wr_byte[BYTE_H]) begin
        aif.acc[15:8] <= aif.wr_data;
      end else if (aif.wr_byte[BYTE_U]) begin
        aif.acc[ACC_W-1:16] <= aif.wr_data[UPR_W-1:0];  // [RQ1]
      end else if (aif.tick) begin
        aif.acc <= sum[ACC_W-1:0];  // [RQ12] [RQ2]
        aif.ovf <= sum[ACC_W];      // [RQ12]
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/nco_core.sv
`timescale 1ns/1ps
`default_nettype none
module nco_core (
  input  wire logic                       clk,          // 200 MHz system clock
  input  wire logic                       rstn,         // async reset, low
  input  wire logic                       ce,           // clock enable
  input  wire logic [nco_pkg::ADDR_W-1:0] addr,         // register address
  input  wire logic [nco_pkg::DATA_W-1:0] wr_data,      // write data
  input  wire logic                       wr_en,        // write strobe
  input  wire logic                       rd_en,        // read strobe
  output var  logic [nco_pkg::DATA_W-1:0] rd_data,      // read data, next cycle
  input  wire logic [nco_pkg::NSRC-1:0]   osc_clk_src,  // input clock candidates
  output var  logic                       osc_out,      // final waveform
  output var  logic                       irq           // interrupt level
);
  import nco_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic                osc_enable_bit;
  logic                osc_polarity_bit;
  logic                pulse_mode_select;
  logic [PWS_W-1:0]    pulse_width_select;
  logic [CKS_W-1:0]    input_clock_select;
  logic [ACC_W-1:0]    step_value;
  logic [ACC_W-1:0]    step_shadow;
  logic                load_pend;
  logic                overflow_irq_flag;
  logic                overflow_irq_enable;
  logic                osc_output_state;
  logic [PCNT_W-1:0]   pcnt;
  logic                sel_q;
  logic [NSRC-1:0]     src_s;
  logic                sel_now;
  logic                rise;
  logic                fall;
  logic [PCNT_W-1:0]   width_cnt;
  logic                wr_hit_incl;

  nco_acc_if aif ();

  nco_sync #(.W(NSRC)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    (osc_clk_src),
    .q    (src_s)
  );

  nco_accum u_accum (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .aif  (aif)
  );

  // ------------------------------------------------------------
  // input clock edges
  // ------------------------------------------------------------
  // reserved selections give a dead clock
  assign sel_now = (input_clock_select < CKS_W'(NSRC)) ? src_s[input_clock_select] : 1'b0;
  assign rise    = sel_now & ~sel_q;
  assign fall    = ~sel_now & sel_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= 1'b0;
    end else if (ce) begin
      sel_q <= sel_now;
    end
  end

  // accumulator link
  assign aif.tick    = rise & osc_enable_bit;  // [RQ12]
  assign aif.step    = step_shadow;
  assign aif.wr_data = wr_data;
  assign aif.wr_byte = {wr_en && addr == ADR_ACCU, wr_en && addr == ADR_ACCH,
                        wr_en && addr == ADR_ACCL};
  assign wr_hit_incl = wr_en && addr == ADR_INCL;
  assign width_cnt   = PCNT_ONE << pulse_width_select;  // [RQ10]

  // ------------------------------------------------------------
  // configuration writes
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_enable_bit      <= 1'b0;
      osc_polarity_bit    <= 1'b0;
      pulse_mode_select   <= 1'b0;
      pulse_width_select  <= '0;
      input_clock_select  <= '0;
      step_value          <= RST_STEP;
      overflow_irq_enable <= 1'b0;
    end else if (ce && wr_en) begin
      if (addr == ADR_CTRL) begin
        osc_enable_bit    <= wr_data[CTRL_EN];
        osc_polarity_bit  <= wr_data[CTRL_POL];
        pulse_mode_select <= wr_data[CTRL_PFM];
      end else if (addr == ADR_CLK) begin
        pulse_width_select <= wr_data[CLK_PWS +: PWS_W];
        input_clock_select <= wr_data[CKS_W-1:0];
      end else if (addr == ADR_INCL) begin
        step_value[7:0] <= wr_data;  // [RQ4]
      end else if (addr == ADR_INCH) begin
        step_value[15:8] <= wr_data;  // [RQ4]
      end else if (addr == ADR_INCU) begin
        step_value[ACC_W-1:16] <= wr_data[UPR_W-1:0];  // [RQ4] [RQ7]
      end else if (addr == ADR_IEN) begin
        overflow_irq_enable <= wr_data[IRQ_OVF];
      end
    end
  end

  // ------------------------------------------------------------
  // step shadow
  // ------------------------------------------------------------
  // a low-byte write landing on a fall waits for the next fall,
  // so the copy never misses the freshly written byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      load_pend   <= 1'b0;
      step_shadow <= RST_STEP;
    end else if (ce) begin
      if (wr_hit_incl) begin
        load_pend <= 1'b1;  // [RQ5]
      end else if (fall) begin
        load_pend <= 1'b0;
      end
      if (fall && load_pend) begin
        step_shadow <= step_value;  // [RQ5] [RQ6]
      end
    end
  end

  // ------------------------------------------------------------
  // waveform
  // ------------------------------------------------------------
  // overflow during a pulse reloads the count, so long widths never drop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_output_state <= 1'b0;
      pcnt             <= '0;
    end else if (ce) begin
      if (!osc_enable_bit) begin
        osc_output_state <= 1'b0;
        pcnt             <= '0;
      end else if (aif.ovf && pulse_mode_select) begin
        osc_output_state <= 1'b1;  // [RQ9] [RQ10]
        pcnt             <= width_cnt;
      end else if (aif.ovf) begin
        osc_output_state <= ~osc_output_state;  // [RQ9]
      end else if (pulse_mode_select && osc_output_state && aif.tick) begin
        if (pcnt <= PCNT_ONE) begin
          osc_output_state <= 1'b0;  // [RQ10]
        end
        pcnt <= pcnt - PCNT_ONE;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt
  // ------------------------------------------------------------
  // a new overflow wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overflow_irq_flag <= 1'b0;
    end else if (ce) begin
      if (aif.ovf) begin
        overflow_irq_flag <= 1'b1;  // [RQ8]
      end else if (wr_en && addr == ADR_ICLR && wr_data[IRQ_OVF]) begin
        overflow_irq_flag <= 1'b0;  // [RQ8]
      end
    end
  end

  // registered pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_out <= 1'b0;
      irq     <= 1'b0;
    end else if (ce) begin
      osc_out <= osc_output_state ^ osc_polarity_bit;  // [RQ11]
      irq     <= overflow_irq_flag & overflow_irq_enable;
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  // accumulator bytes are sampled live; no snapshot across bytes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= RST_BYTE;
    end else if (ce) begin
      rd_data <= RST_BYTE;
      if (rd_en) begin
        if (addr == ADR_CTRL) begin
          rd_data[CTRL_EN]  <= osc_enable_bit;
          rd_data[CTRL_OUT] <= osc_output_state ^ osc_polarity_bit;
          rd_data[CTRL_POL] <= osc_polarity_bit;
          rd_data[CTRL_PFM] <= pulse_mode_select;
        end else if (addr == ADR_CLK) begin
          rd_data <= {pulse_width_select, 1'b0, input_clock_select};
        end else if (addr == ADR_ACCL) begin
          rd_data <= aif.acc[7:0];  // [RQ2]
        end else if (addr == ADR_ACCH) begin
          rd_data <= aif.acc[15:8];  // [RQ2]
        end else if (addr == ADR_ACCU) begin
          rd_data <= {UPR_PAD, aif.acc[ACC_W-1:16]};  // [RQ1] [RQ7]
        end else if (addr == ADR_INCL) begin
          rd_data <= step_value[7:0];
        end else if (addr == ADR_INCH) begin
          rd_data <= step_value[15:8];
        end else if (addr == ADR_INCU) begin
          rd_data <= {UPR_PAD, step_value[ACC_W-1:16]};  // [RQ7]
        end else if (addr == ADR_ISTAT) begin
          rd_data[IRQ_OVF] <= overflow_irq_flag;
        end else if (addr == ADR_IEN) begin
          rd_data[IRQ_OVF] <= overflow_irq_enable;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_accu_read;
    ce && rd_en && addr == ADR_ACCU |=> rd_data == {UPR_PAD, $past(aif.acc[ACC_W-1:16])};
  endproperty
  a_accu_read: assert property (p_accu_read) else $error("upper accumulator read wrong");  // [RQ1]

  property p_accl_live;
    ce && rd_en && addr == ADR_ACCL |=> rd_data == $past(aif.acc[7:0]);
  endproperty
  a_accl_live: assert property (p_accl_live) else $error("low accumulator read stale");  // [RQ2]

  property p_incu_pad;
    ce && rd_en && addr == ADR_INCU |=> rd_data[7:UPR_W] == UPR_PAD;
  endproperty
  a_incu_pad: assert property (p_incu_pad) else $error("upper step pad bits set");  // [RQ7]

  property p_shadow_load;
    ce && fall && load_pend && !wr_en |=> step_shadow == $past(step_value);
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("shadow not reloaded");  // [RQ5]

  property p_pend_hold;
    ce && wr_hit_incl ##1 (ce && !fall) |=> load_pend;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("reload request lost");  // [RQ5]

  property p_add;
    ce && aif.tick && aif.wr_byte == 3'b000 |=>
      aif.acc == ACC_W'($past(aif.acc) + $past(step_shadow)) ##0 aif.ovf == ($past(aif.acc) > ~$past(step_shadow));
  endproperty
  a_add: assert property (p_add) else $error("accumulate or carry wrong");  // [RQ12]

  property p_flag_set;
    ce && aif.ovf |=> overflow_irq_flag ##1 (!$past(ce) || irq == $past(overflow_irq_enable));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");  // [RQ8]

  property p_toggle;
    ce && aif.ovf && osc_enable_bit && !pulse_mode_select |=> osc_output_state != $past(osc_output_state);
  endproperty
  a_toggle: assert property (p_toggle) else $error("fixed duty did not toggle");  // [RQ9]

  property p_pulse_load;
    ce && aif.ovf && osc_enable_bit && pulse_mode_select |=> osc_output_state && pcnt == $past(width_cnt);
  endproperty
  a_pulse_load: assert property (p_pulse_load) else $error("pulse start wrong");  // [RQ10]

  property p_polarity;
    ce |=> osc_out == ($past(osc_output_state) ^ $past(osc_polarity_bit));
  endproperty
  a_polarity: assert property (p_polarity) else $error("output polarity wrong");  // [RQ11]

  property p_flag_clear;
    ce && wr_en && addr == ADR_ICLR && wr_data[IRQ_OVF] && !aif.ovf |=> !overflow_irq_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("overflow flag not cleared");  // [RQ8]

  property p_irq_level;
    ce |=> irq == ($past(overflow_irq_flag) && $past(overflow_irq_enable));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");  // [RQ8]

  property p_pulse_end;
    ce && osc_enable_bit && pulse_mode_select && osc_output_state && aif.tick && !aif.ovf
      && pcnt <= PCNT_ONE |=> !osc_output_state;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end");  // [RQ10]

  // a stopped oscillator neither adds nor drives its waveform
  property p_disabled;
    ce && !osc_enable_bit |=> !osc_output_state && !aif.ovf;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled oscillator active");  // [RQ12]

  c_pulse:  cover property (aif.ovf && pulse_mode_select ##[1:300] !osc_output_state);
  c_reload: cover property (fall && load_pend);
  c_irq:    cover property (irq ##1 wr_en && addr == ADR_ICLR);
  c_toggle: cover property (aif.ovf && !pulse_mode_select && osc_enable_bit);
endmodule
`default_nettype wire

// File: verif/nco_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nco_core_tb;
  import nco_pkg::*;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic              clk;
  logic              rstn;
  logic              ce;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rd_data;
  logic [NSRC-1:0]   osc_clk_src;
  logic              osc_out;
  logic              irq;
  int                err_total;
  int                samples_checked;
  int                n;
  logic [31:0]       seed;
  logic [NSRC-1:0]   src_bit;
  logic [3:0]        sel;
  logic [DATA_W-1:0] rv;
  logic [19:0]       st;
  logic [19:0]       a0;
  logic [19:0]       got;
  logic [20:0]       e;
  logic              pol;

  // free-running 200 MHz clock
  always #2.5 clk = ~clk;

  nco_core u_nco_core (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .osc_clk_src(osc_clk_src),
    .osc_out(osc_out), .irq(irq));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // shift register source of repeatable random values
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // accumulator after n adds; top bit flags a wrap past 20 bits
  function automatic logic [20:0] acc_after(input logic [19:0] a, input logic [19:0] s,
                                            input int k);
    logic [31:0] sum;
    sum = a + k * s;
    return {sum > 32'h000FFFFF, sum[19:0]};
  endfunction

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // strobe low for a cycle after each access, so no signal is set twice per step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    rv = rd_data;
    @(posedge clk);
  endtask

  // lets a flag launched at the last bus edge settle before it is looked at
  task automatic idle;
    repeat (2) @(posedge clk);
  endtask

  // selected input clock: 8 cycles high, 8 low, well above the synchroniser minimum
  task automatic pulse(input int k);
    repeat (k) begin
      osc_clk_src <= src_bit;
      repeat (8) @(posedge clk);
      osc_clk_src <= '0;
      repeat (8) @(posedge clk);
    end
  endtask

  // upper and high first, low last; one input clock fall then moves it to the shadow
  task automatic wr_step(input logic [19:0] s);
    wr(ADR_INCU, {4'h0, s[19:16]});
    wr(ADR_INCH, s[15:8]);
    wr(ADR_INCL, s[7:0]);
    pulse(1);
  endtask

  task automatic wr_acc(input logic [19:0] a);  // called only while disabled
    wr(ADR_ACCL, a[7:0]);
    wr(ADR_ACCH, a[15:8]);
    wr(ADR_ACCU, {4'h0, a[19:16]});
  endtask

  // only read with the oscillator stopped: byte reads are not atomic
  task automatic rd_acc(output logic [19:0] v);
    rd(ADR_ACCL);
    v[7:0] = rv;
    rd(ADR_ACCH);
    v[15:8] = rv;
    rd(ADR_ACCU);
    v[19:16] = rv[3:0];
    chk(rv[7:4], 4'h0);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog, far beyond the expected six thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    finish_test;
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    osc_clk_src = '0;
    err_total = 0;
    samples_checked = 0;
    seed = 32'h56154046;
    src_bit = 11'h001;
    sel = 4'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // reset values across the map, unmapped offsets included
    for (int a = 0; a < 16; a++) begin
      rd(a[ADDR_W-1:0]);
      chk(rv, (a == 5) ? 8'h01 : 8'h00);
    end
    chk(irq, 1'b0);
    wr(ADR_ACCU, 8'hFF);
    wr(ADR_INCU, 8'hFF);
    rd(ADR_ACCU);
    chk(rv, 8'h0F);
    rd(ADR_INCU);
    chk(rv, 8'h0F);
    $display("test reset done");
    // random steps, sources and start points; high byte rewritten without a low write
    for (int t = 0; t < 6; t++) begin
      seed = lfsr(seed);
      sel = seed[3:0] % 11;
      src_bit = 11'h001 << sel;
      wr(ADR_CLK, {4'h0, sel});
      seed = lfsr(seed);
      st = (t == 0) ? 20'hFFFFF : seed[19:0];
      seed = lfsr(seed);
      a0 = (t == 1) ? 20'hFFFFF : seed[31:12];
      n = 3 + seed[2:0] % 6;
      wr_step(st);
      wr_acc(a0);
      wr(ADR_CTRL, 8'h80);
      pulse(n);
      wr(ADR_INCH, ~st[15:8]);
      pulse(2);
      wr(ADR_CTRL, 8'h00);
      e = acc_after(a0, st, n + 2);
      rd_acc(got);
      chk(got, e[19:0]);
      rd(ADR_ISTAT);
      chk(rv, {7'h00, e[20]});
      chk(irq, 1'b0);
      wr(ADR_ICLR, 8'h01);
    end
    $display("test accumulate done");
    // fixed duty: step of half range overflows every second rise
    wr_step(20'h80000);
    wr_acc(20'h00000);
    wr(ADR_IEN, 8'h01);
    wr(ADR_CTRL, 8'h80);
    for (int k = 1; k <= 4; k++) begin
      pulse(2);
      chk(osc_out, k[0]);
      rd(ADR_CTRL);
      chk(rv, {2'b10, k[0], 5'h00});
    end
    chk(irq, 1'b1);
    wr(ADR_IEN, 8'h00);
    idle;
    chk(irq, 1'b0);
    rd(ADR_ISTAT);
    chk(rv, 8'h01);
    wr(ADR_IEN, 8'h01);
    idle;
    chk(irq, 1'b1);
    wr(ADR_ICLR, 8'h01);
    idle;
    chk(irq, 1'b0);
    rd(ADR_ISTAT);
    chk(rv, 8'h00);
    wr(ADR_CTRL, 8'h10);
    idle;
    chk(osc_out, 1'b1);
    $display("test duty and irq done");
    // pulse mode, every width code, random polarity
    for (int p = 0; p < 8; p++) begin
      seed = lfsr(seed);
      pol = seed[0];
      wr(ADR_CTRL, 8'h00);
      wr(ADR_CLK, {p[2:0], 1'b0, sel});
      wr_step(20'h00001);
      wr_acc(20'hFFFFF);
      wr(ADR_CTRL, {3'b100, pol, 3'b000, 1'b1});
      pulse(1);
      chk(osc_out, !pol);
      pulse((1 << p) - 1);
      chk(osc_out, !pol);
      pulse(1);
      chk(osc_out, pol);
    end
    // clock enable low freezes the register port: the enable write is lost
    ce <= 1'b0;
    wr(ADR_IEN, 8'h00);
    ce <= 1'b1;
    rd(ADR_IEN);
    chk(rv, 8'h01);
    $display("test pulse done");
    finish_test;
  end
endmodule
`default_nettype wire
